// *** fa_dma_pkg.sv ***
// Shared constants, register map and types for the frame acquisition DMA block
package fa_dma_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CMD        = 8'h00;  // Command code, write only
  localparam logic [7:0] OFF_STATUS     = 8'h04;  // Block state, read only
  localparam logic [7:0] OFF_PITCH      = 8'h08;  // Signed line pitch in bytes
  localparam logic [7:0] OFF_START      = 8'h0c;  // Byte offset of first line
  localparam logic [7:0] OFF_COUNT      = 8'h10;  // Bytes written this run
  localparam logic [7:0] OFF_INT_STATUS = 8'h14;  // Sticky events, read only
  localparam logic [7:0] OFF_INT_ENABLE = 8'h18;  // Event enables
  localparam logic [7:0] OFF_INT_CLEAR  = 8'h1c;  // Write one to clear
  localparam logic [7:0] OFF_TABLE      = 8'h40;  // Page address table base
  // ----------------------------------------
  // Sizes and reset values
  // ----------------------------------------
  localparam int          PAGE_BITS     = 12;     // 4K byte pages
  localparam int          TABLE_DEPTH   = 16;     // Entries in the table
  localparam int          TABLE_AW      = 4;      // Table index width
  localparam int          EVT_W         = 4;      // Number of event bits
  localparam logic [31:0] PITCH_RST     = 32'h0000_0000;
  localparam logic [31:0] START_RST     = 32'h0000_0000;
  localparam logic [31:0] WORD_BYTES    = 32'h0000_0004;
  // ----------------------------------------
  // Event bit positions
  // ----------------------------------------
  localparam int EVT_FRAME_DONE = 0;  // Frame fully in memory
  localparam int EVT_STARTED    = 1;  // First frame of a run began
  localparam int EVT_REJECT     = 2;  // Command refused
  localparam int EVT_OVERFLOW   = 3;  // Pixel lost, engine halted
  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE        = 3'b000,
    CMD_CONTINUOUS  = 3'b001,
    CMD_SINGLE      = 3'b010,
    CMD_STOP_AT_END = 3'b011,
    CMD_STOP_NOW    = 3'b100,
    CMD_RECOVER     = 3'b101,
    CMD_DMA_START   = 3'b110,
    CMD_DMA_IDLE    = 3'b111
  } cmd_e;
  // ----------------------------------------
  // Acquisition states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,  // Engine not started
    ST_READY  = 3'b001,  // Configured, not acquiring
    ST_ARMED  = 3'b010,  // Waiting for a frame start
    ST_ACTIVE = 3'b011,  // Moving a frame
    ST_HALTED = 3'b100   // Stopped hard or overflowed
  } acq_state_e;
endpackage : fa_dma_pkg

// *** fa_dma_if.sv ***
// Word write channel between the acquisition control and the memory writer
`timescale 1ns/1ps
interface fa_dma_if;
  logic        req;   // Word offered, one-cycle pulse
  logic [31:0] addr;  // Physical byte address
  logic [31:0] data;  // Pixel word
  logic        busy;  // Writer holds a word
  logic        ack;   // Word reached memory, pulse
  modport ctl (output req, output addr, output data, input busy, input ack);
  modport eng (input req, input addr, input data, output busy, output ack);
endinterface : fa_dma_if

// *** fa_dma_writer.sv ***
// One-word memory write stage with valid/ready toward host memory
`timescale 1ns/1ps
module fa_dma_writer (
  input  wire logic  pclk,
  input  wire logic  presetn,
  fa_dma_if.eng      ch,
  output logic       mem_valid,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_data,
  input  wire logic  mem_ready
);
  // ----------------------------------------
  // Hold stage
  // ----------------------------------------
  logic ack_r;  // Completion pulse

  // Load one word, keep it until memory takes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_valid <= 1'b0;
      mem_addr  <= 32'h0000_0000;
      mem_data  <= 32'h0000_0000;
    end else if (mem_valid) begin
      if (mem_ready) begin
        mem_valid <= 1'b0;  // Handed over
      end
    end else if (ch.req) begin
      mem_valid <= 1'b1;
      mem_addr  <= ch.addr;
      mem_data  <= ch.data;
    end
  end

  // Pulse when the word lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= mem_valid & mem_ready;
    end
  end

  assign ch.busy = mem_valid;
  assign ch.ack  = ack_r;
endmodule : fa_dma_writer

// *** fa_irq_ctrl.sv ***
// Sticky event status, enable mask and level interrupt output
`timescale 1ns/1ps
module fa_irq_ctrl (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] evt_set,
  input  wire logic [3:0] evt_clr,
  input  wire logic [3:0] evt_en,
  output logic      [3:0] evt_status,
  output logic            irq
);
  // ----------------------------------------
  // Status and line
  // ----------------------------------------
  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status <= 4'h0;
    end else begin
      evt_status <= (evt_status & ~evt_clr) | evt_set;
    end
  end

  // Registered level, high while an enabled bit stands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_status & evt_en);
    end
  end
endmodule : fa_irq_ctrl

// *** fa_acq_dma.sv ***
// Frame acquisition control and scatter-gather DMA with APB registers
`timescale 1ns/1ps
//
// Functional notes
// - Continuous: wait frame start, take every frame
// - Single: wait frame start, take one frame
// - Stop at end: finish frame, then cease
// - Immediate stop halts mid-frame, drops rest
// - After immediate stop, refuse until recover
// - Recover restores configured acquisition and DMA state
// - Capture commands while running are rejected
// - Frame done event when last word lands
// - Page table scatters data per 4K page
// - Signed line pitch, negative allowed
// - Readable count of bytes moved
// - Detectable start of first continuous frame
// - Engine started after table load, idled on cleanup
module fa_acq_dma (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        frame_start,
  input  wire logic        line_end,
  input  wire logic        frame_end,
  input  wire logic        pix_valid,
  input  wire logic [31:0] pix_data,
  output logic             mem_valid,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_data,
  input  wire logic        mem_ready,
  output logic             irq
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // True when an APB address is word aligned and inside the table window
  function automatic logic table_hit(input logic [31:0] a);
    table_hit = (a[31:6] == {24'h00_0000, fa_dma_pkg::OFF_TABLE[7:6]}) && (a[1:0] == 2'b00);
  endfunction : table_hit

  // Virtual byte offset to physical address through the page table
  function automatic logic [31:0] phys_of(input logic [31:0] base, input logic [31:0] off);
    phys_of = {base[31:fa_dma_pkg::PAGE_BITS], off[fa_dma_pkg::PAGE_BITS-1:0]};
  endfunction : phys_of

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  fa_dma_if ch ();                                   // Writer channel
  fa_dma_pkg::acq_state_e state_r;                   // Acquisition state
  logic                   cont_r;                    // Continuous run
  logic                   first_r;                   // First frame not yet begun
  logic                   eof_pend_r;                // Frame ended, draining
  logic                   ovf_r;                     // Latched overflow
  logic                   stopped_r;                 // Latched immediate stop
  logic                   dma_on_r;                  // Engine started
  logic            [31:0] pitch_r;                   // Signed line pitch
  logic            [31:0] start_r;                   // First line offset
  logic            [31:0] count_r;                   // Bytes landed
  logic            [31:0] line_r;                    // Current line offset
  logic            [31:0] col_r;                     // Byte within line
  logic            [31:0] table_r [fa_dma_pkg::TABLE_DEPTH];  // Page addresses
  logic             [3:0] evt_en_r;                  // Interrupt enables
  logic             [3:0] evt_clr;                   // Clear strobes
  logic             [3:0] evt_set;                   // Event pulses
  logic             [3:0] evt_status;                // Sticky events
  logic                   reject_evt;                // Refused command
  logic                   start_evt;                 // Run began
  logic                   done_evt;                  // Frame landed
  logic                   ovf_evt;                   // Pixel lost
  logic                   push;                      // Word offered
  logic            [31:0] voff;                      // Virtual byte offset
  logic                   apb_acc;                   // Access phase
  logic                   wr_en;                     // Write takes effect
  logic                   cmd_wr;                    // Command write
  fa_dma_pkg::cmd_e       cmd;                       // Decoded command
  logic            [31:0] rd_word;                   // Read mux
  logic                   rd_ok;                     // Address is mapped

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // One wait state keeps pready, prdata and pslverr on flops
  assign apb_acc = psel & penable;
  assign wr_en   = apb_acc & pwrite & pready & ~pslverr;
  assign cmd_wr  = wr_en & (paddr[7:0] == fa_dma_pkg::OFF_CMD) & (paddr[31:8] == 24'h00_0000);
  assign cmd     = fa_dma_pkg::cmd_e'(pwdata[2:0]);

  // Read decode; unmapped answers with an error and zero data
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (table_hit(paddr)) begin
      rd_word = table_r[paddr[5:2]];
    end else if (paddr[31:8] != 24'h00_0000) begin
      rd_ok = 1'b0;
    end else begin
      case (paddr[7:0])
        fa_dma_pkg::OFF_CMD:        rd_word = 32'h0000_0000;  // Write only
        fa_dma_pkg::OFF_STATUS:     rd_word = {24'h00_0000, dma_on_r, stopped_r, ovf_r,
                                               eof_pend_r, cont_r, state_r};
        fa_dma_pkg::OFF_PITCH:      rd_word = pitch_r;
        fa_dma_pkg::OFF_START:      rd_word = start_r;
        fa_dma_pkg::OFF_COUNT:      rd_word = count_r;
        fa_dma_pkg::OFF_INT_STATUS: rd_word = {28'h000_0000, evt_status};
        fa_dma_pkg::OFF_INT_ENABLE: rd_word = {28'h000_0000, evt_en_r};
        fa_dma_pkg::OFF_INT_CLEAR:  rd_word = 32'h0000_0000;  // Write only
        default:                    rd_ok   = 1'b0;
      endcase
    end
  end

  // Answer one cycle into the access phase, then drop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (apb_acc & ~pready) begin
      pready  <= 1'b1;
      pslverr <= ~rd_ok;
      prdata  <= pwrite ? 32'h0000_0000 : rd_word;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Pitch and first-line offset are fixed for a run by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pitch_r  <= fa_dma_pkg::PITCH_RST;
      start_r  <= fa_dma_pkg::START_RST;
      evt_en_r <= 4'h0;
    end else if (wr_en && paddr[31:8] == 24'h00_0000) begin
      case (paddr[7:0])
        fa_dma_pkg::OFF_PITCH:      pitch_r  <= pwdata;
        fa_dma_pkg::OFF_START:      start_r  <= pwdata;
        fa_dma_pkg::OFF_INT_ENABLE: evt_en_r <= pwdata[3:0];
        default:                    pitch_r  <= pitch_r;
      endcase
    end
  end

  // Page address table; host loads it before starting the engine
  always_ff @(posedge pclk) begin
    if (wr_en && table_hit(paddr)) begin
      table_r[paddr[5:2]] <= pwdata;
    end
  end

  // Clear strobes for the sticky events
  assign evt_clr = (wr_en && paddr == {24'h00_0000, fa_dma_pkg::OFF_INT_CLEAR}) ? pwdata[3:0] : 4'h0;

  // ----------------------------------------
  // Acquisition control
  // ----------------------------------------
  // Main state; commands, frame markers and faults steer it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= fa_dma_pkg::ST_IDLE;
      cont_r  <= 1'b0;
      first_r <= 1'b0;
    end else if (ovf_evt) begin
      state_r <= fa_dma_pkg::ST_HALTED;
      cont_r  <= 1'b0;
    end else if (cmd_wr) begin
      case (cmd)
        fa_dma_pkg::CMD_CONTINUOUS,
        fa_dma_pkg::CMD_SINGLE: begin
          // Only a configured, quiet engine takes a capture
          if (state_r == fa_dma_pkg::ST_READY) begin
            state_r <= fa_dma_pkg::ST_ARMED;
            cont_r  <= (cmd == fa_dma_pkg::CMD_CONTINUOUS);
            first_r <= 1'b1;
          end
        end
        fa_dma_pkg::CMD_STOP_AT_END: begin
          cont_r <= 1'b0;
          if (state_r == fa_dma_pkg::ST_ARMED) begin
            state_r <= fa_dma_pkg::ST_READY;
          end
        end
        fa_dma_pkg::CMD_STOP_NOW: begin
          if (state_r != fa_dma_pkg::ST_IDLE) begin
            state_r <= fa_dma_pkg::ST_HALTED;
          end
          cont_r <= 1'b0;
        end
        fa_dma_pkg::CMD_RECOVER: begin
          if (state_r == fa_dma_pkg::ST_HALTED) begin
            state_r <= fa_dma_pkg::ST_READY;
          end
        end
        fa_dma_pkg::CMD_DMA_START: begin
          if (state_r == fa_dma_pkg::ST_IDLE) begin
            state_r <= fa_dma_pkg::ST_READY;
          end
        end
        fa_dma_pkg::CMD_DMA_IDLE: begin
          state_r <= fa_dma_pkg::ST_IDLE;
          cont_r  <= 1'b0;
        end
        default: state_r <= state_r;
      endcase
    end else begin
      case (state_r)
        fa_dma_pkg::ST_ARMED: begin
          if (frame_start) begin
            state_r <= fa_dma_pkg::ST_ACTIVE;
            first_r <= 1'b0;
          end
        end
        fa_dma_pkg::ST_ACTIVE: begin
          if (frame_end) begin
            // Continuous waits for the next frame, single ends here
            state_r <= cont_r ? fa_dma_pkg::ST_ARMED : fa_dma_pkg::ST_READY;
          end
        end
        default: state_r <= state_r;
      endcase
    end
  end

  // Fault latches; only recover or cleanup clears them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_r     <= 1'b0;
      stopped_r <= 1'b0;
    end else if (ovf_evt) begin
      ovf_r <= 1'b1;
    end else if (cmd_wr && (cmd == fa_dma_pkg::CMD_RECOVER || cmd == fa_dma_pkg::CMD_DMA_IDLE)) begin
      ovf_r     <= 1'b0;
      stopped_r <= 1'b0;
    end else if (cmd_wr && cmd == fa_dma_pkg::CMD_STOP_NOW && state_r != fa_dma_pkg::ST_IDLE) begin
      stopped_r <= 1'b1;
    end
  end

  // Engine running flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_on_r <= 1'b0;
    end else if (cmd_wr && cmd == fa_dma_pkg::CMD_DMA_START) begin
      dma_on_r <= 1'b1;
    end else if (cmd_wr && cmd == fa_dma_pkg::CMD_DMA_IDLE) begin
      dma_on_r <= 1'b0;
    end
  end

  // Capture refused: running, halted, or engine not set up
  assign reject_evt = cmd_wr && (cmd == fa_dma_pkg::CMD_CONTINUOUS || cmd == fa_dma_pkg::CMD_SINGLE)
                      && state_r != fa_dma_pkg::ST_READY;
  assign start_evt  = ~cmd_wr & ~ovf_evt & (state_r == fa_dma_pkg::ST_ARMED) & frame_start & first_r;

  // ----------------------------------------
  // Address generation
  // ----------------------------------------
  // Line base moves by the signed pitch; column by whole words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_r <= 32'h0000_0000;
      col_r  <= 32'h0000_0000;
    end else if (state_r == fa_dma_pkg::ST_ARMED && frame_start) begin
      line_r <= start_r;
      col_r  <= 32'h0000_0000;
    end else if (state_r == fa_dma_pkg::ST_ACTIVE) begin
      if (line_end) begin
        line_r <= line_r + pitch_r;
        col_r  <= 32'h0000_0000;
      end else if (push) begin
        col_r <= col_r + fa_dma_pkg::WORD_BYTES;
      end
    end
  end

  // A word lost to a busy writer is an overflow, never a stall
  assign voff    = line_r + col_r;
  assign push    = (state_r == fa_dma_pkg::ST_ACTIVE) & pix_valid & ~ch.busy & ~(cmd_wr & cmd == fa_dma_pkg::CMD_STOP_NOW);
  assign ovf_evt = (state_r == fa_dma_pkg::ST_ACTIVE) & pix_valid & ch.busy;

  assign ch.req  = push;
  assign ch.addr = phys_of(table_r[voff[fa_dma_pkg::PAGE_BITS+fa_dma_pkg::TABLE_AW-1:fa_dma_pkg::PAGE_BITS]],
                           voff);
  assign ch.data = pix_data;

  // ----------------------------------------
  // Completion and progress
  // ----------------------------------------
  // Frame done waits until the last word has landed in memory
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eof_pend_r <= 1'b0;
    end else if (ovf_evt || (cmd_wr && (cmd == fa_dma_pkg::CMD_STOP_NOW || cmd == fa_dma_pkg::CMD_RECOVER))) begin
      eof_pend_r <= 1'b0;
    end else if (state_r == fa_dma_pkg::ST_ACTIVE && frame_end) begin
      eof_pend_r <= 1'b1;
    end else if (done_evt) begin
      eof_pend_r <= 1'b0;
    end
  end
  assign done_evt = eof_pend_r & ~ch.busy & ~ch.req;

  // Bytes landed since the last accepted capture or recover
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= 32'h0000_0000;
    end else if (cmd_wr && state_r == fa_dma_pkg::ST_READY &&
                 (cmd == fa_dma_pkg::CMD_CONTINUOUS || cmd == fa_dma_pkg::CMD_SINGLE)) begin
      count_r <= 32'h0000_0000;
    end else if (cmd_wr && cmd == fa_dma_pkg::CMD_RECOVER) begin
      count_r <= 32'h0000_0000;
    end else if (ch.ack) begin
      count_r <= count_r + fa_dma_pkg::WORD_BYTES;
    end
  end

  // ----------------------------------------
  // Events and submodules
  // ----------------------------------------
  always_comb begin
    evt_set                             = 4'h0;
    evt_set[fa_dma_pkg::EVT_FRAME_DONE] = done_evt;
    evt_set[fa_dma_pkg::EVT_STARTED]    = start_evt;
    evt_set[fa_dma_pkg::EVT_REJECT]     = reject_evt;
    evt_set[fa_dma_pkg::EVT_OVERFLOW]   = ovf_evt;
  end

  fa_irq_ctrl u_irq (
    .pclk       (pclk),
    .presetn    (presetn),
    .evt_set    (evt_set),
    .evt_clr    (evt_clr),
    .evt_en     (evt_en_r),
    .evt_status (evt_status),
    .irq        (irq)
  );

  fa_dma_writer u_writer (
    .pclk      (pclk),
    .presetn   (presetn),
    .ch        (ch),
    .mem_valid (mem_valid),
    .mem_addr  (mem_addr),
    .mem_data  (mem_data),
    .mem_ready (mem_ready)
  );
endmodule : fa_acq_dma

// *** fa_acq_dma_assertions.sv ***
// Port checker for the frame acquisition DMA block
`timescale 1ns/1ps
module fa_acq_dma_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        frame_start,
  input wire logic        line_end,
  input wire logic        frame_end,
  input wire logic        pix_valid,
  input wire logic [31:0] pix_data,
  input wire logic        mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_data,
  input wire logic        mem_ready,
  input wire logic        irq
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  property p_ready_lat; psel && penable && !$past(penable) |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_ready_req; pready |-> psel && penable; endproperty
  property p_err_zero; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_ready_lat: assert property (p_ready_lat) else $error("late bus answer");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
  a_ready_req: assert property (p_ready_req) else $error("ready without access");
  a_err_zero: assert property (p_err_zero) else $error("error answer carries data");
  // ----------------------------------------
  // Memory writes
  // ----------------------------------------
  property p_mem_hold; mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr) && $stable(mem_data); endproperty
  property p_mem_word; $rose(mem_valid) |-> $past(pix_valid) && mem_data == $past(pix_data); endproperty
  property p_mem_fell; $fell(mem_valid) |-> $past(mem_ready); endproperty
  // A new word may only follow a handshake if a pixel came with it
  property p_mem_once; mem_valid && mem_ready |=> !mem_valid || $past(pix_valid); endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("write changed while waiting");
  a_mem_word: assert property (p_mem_word) else $error("write not from pixel");
  a_mem_fell: assert property (p_mem_fell) else $error("write dropped unaccepted");
  a_mem_once: assert property (p_mem_once) else $error("word written twice");
  // Main scenarios reached
  c_word: cover property (mem_valid && mem_ready);
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
endmodule : fa_acq_dma_assertions

bind fa_acq_dma fa_acq_dma_assertions u_fa_acq_dma_assertions (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .frame_start, .line_end, .frame_end,
  .pix_valid, .pix_data, .mem_valid, .mem_addr, .mem_data, .mem_ready, .irq);

// *** cam_mem_model.sv ***
// Camera frame source and host memory acceptor model
`timescale 1ns/1ps
module cam_mem_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic        burst,
  input  wire logic        stall,
  output logic             busy,
  output logic             frame_start,
  output logic             line_end,
  output logic             frame_end,
  output logic             pix_valid,
  output logic      [31:0] pix_data,
  output logic             mem_ready
);
  logic [5:0] step_r;  // Place in the frame, zero when idle
  logic [7:0] tick_r;  // Free running, scrambles idle data
  // ----------------------------------------
  // Frame sequencer: two lines of two words
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_r <= 6'h00;
      tick_r <= 8'h00;
    end else begin
      tick_r <= tick_r + 8'h01;
      if (step_r != 6'h00) step_r <= (step_r == 6'h20) ? 6'h00 : step_r + 6'h01;
      else if (go) step_r <= 6'h01;
    end
  end
  assign busy        = (step_r != 6'h00);
  assign frame_start = (step_r == 6'h01);
  assign line_end    = (step_r == 6'h0d) || (step_r == 6'h1d);
  assign frame_end   = (step_r == 6'h1e);
  // Spaced words overrun the writer only while stalled; burst does on purpose
  assign pix_valid = burst ? (step_r >= 6'h04 && step_r <= 6'h0c)
                           : (step_r[2:0] == 3'h4 && step_r <= 6'h1c);
  // Data is only meaningful with pix_valid, so it keeps changing
  assign pix_data  = {4{tick_r}};
  // Memory answers every other cycle, never while stalled
  assign mem_ready = !stall && tick_r[0];
endmodule : cam_mem_model

// *** fa_acq_dma_tb.sv ***
// Self-checking testbench for the frame acquisition DMA block
`timescale 1ns/1ps
module fa_acq_dma_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, mem_addr, mem_data, pix_data, rd, last_addr;
  logic pready, pslverr, frame_start, line_end, frame_end, pix_valid, mem_valid, mem_ready, irq;
  logic go = 1'b0, burst = 1'b0, stall = 1'b0, busy, err;
  int failures = 0, checks = 0;
  always #12.5 pclk = ~pclk;
  fa_acq_dma u_fa_acq_dma (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .frame_start, .line_end, .frame_end, .pix_valid, .pix_data, .mem_valid,
    .mem_addr, .mem_data, .mem_ready, .irq);
  cam_mem_model u_cam_mem_model (.pclk, .presetn, .go, .burst, .stall, .busy, .frame_start,
    .line_end, .frame_end, .pix_valid, .pix_data, .mem_ready);
  // Last address accepted by memory
  always @(posedge pclk) if (mem_valid && mem_ready) last_addr <= mem_addr;
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until the edge where pready is seen high
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask : rd_chk
  task cmd(input logic [31:0] c);
    apb(1'b1, 32'h00, c);
  endtask : cmd
  task st(input logic [31:0] e);
    rd_chk(32'h04, 32'h7, e);
  endtask : st
  // One camera frame, then the count lag settles
  task frame();
    @(posedge pclk) go <= 1'b1;
    @(posedge pclk) go <= 1'b0;
    do @(negedge pclk); while (busy);
    repeat (6) @(posedge pclk);
  endtask : frame
  task end_of_test();
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    end_of_test();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    st(32'h0);
    apb(1'b1, 32'h44, 32'h00ab_c000);  // Page one of the window
    apb(1'b1, 32'h08, 32'hffff_fff0);  // Bottom line first
    apb(1'b1, 32'h0c, 32'h0000_1010);
    apb(1'b1, 32'h18, 32'h0000_000f);
    cmd(32'h6);
    st(32'h1);
    cmd(32'h2);
    st(32'h2);
    frame();
    rd_chk(32'h10, 32'hffff_ffff, 32'h10);
    chk(last_addr, 32'h00ab_c004);
    rd_chk(32'h14, 32'hf, 32'h3);
    chk({31'h0, irq}, 32'h1);
    st(32'h1);
    apb(1'b1, 32'h1c, 32'hf);
    repeat (2) @(posedge pclk);  // Line follows status a cycle late
    chk({31'h0, irq}, 32'h0);
    cmd(32'h1);
    cmd(32'h2);
    rd_chk(32'h14, 32'hf, 32'h4);
    frame();
    frame();
    rd_chk(32'h14, 32'hf, 32'h7);
    cmd(32'h3);
    st(32'h1);
    frame();
    rd_chk(32'h10, 32'hffff_ffff, 32'h20);
    cmd(32'h2);
    @(posedge pclk) go <= 1'b1;
    @(posedge pclk) go <= 1'b0;
    repeat (4) @(posedge pclk);  // Stop lands after the first word only
    cmd(32'h4);
    frame();
    st(32'h4);
    rd_chk(32'h10, 32'hffff_ffff, 32'h4);
    apb(1'b1, 32'h1c, 32'hf);
    cmd(32'h2);
    rd_chk(32'h14, 32'h4, 32'h4);
    cmd(32'h5);
    st(32'h1);
    rd_chk(32'h10, 32'hffff_ffff, 32'h0);
    stall <= 1'b1;
    burst <= 1'b1;
    cmd(32'h2);
    frame();
    rd_chk(32'h14, 32'h8, 32'h8);
    cmd(32'h1);
    st(32'h4);
    stall <= 1'b0;
    burst <= 1'b0;
    cmd(32'h5);
    st(32'h1);
    rd_chk(32'h20, 32'hffff_ffff, 32'h0);
    chk({31'h0, err}, 32'h1);
    cmd(32'h7);
    st(32'h0);
    end_of_test();
  end
endmodule : fa_acq_dma_tb
